// ===== logic/mdc_pkg.sv
/*
  constants, register layout and carrier types of the memory ecc
  diagnostic control block.
  assumes a single 25 mhz clock domain; no timescale needed here.
*/
`default_nettype none
package mdc_pkg;
  // data and check widths of the memory word
  localparam int MDC_DATA_W = 32;
  localparam int MDC_CHECK_W = 7;

  // the two decoded addresses of memory_diag_control
  localparam logic [31:0] MDC_ADDR_MAIN = 32'h1008_0144;
  localparam logic [31:0] MDC_ADDR_DIAG = 32'h2008_0144;

  // field positions of memory_diag_control
  localparam int MDC_CRD_IE_BIT = 12;
  localparam int MDC_FORCE_REF_BIT = 11;
  localparam int MDC_DET_DIS_BIT = 10;
  localparam int MDC_DIAG_MODE_BIT = 7;
  localparam int MDC_CHECK_LSB = 0;
  localparam logic [31:0] MDC_CTRL_RESET = 32'h0000_0000;

  // low three check bits flipped on a bus parity error
  localparam logic [6:0] MDC_PARITY_FLIP = 7'h07;

  // corrected read interrupt identity
  localparam logic [4:0] MDC_CRD_IPL = 5'h1A;
  localparam logic [7:0] MDC_CRD_VECTOR = 8'h54;

  // refresh interval, floor to whole cycles
  localparam int MDC_CLK_PERIOD_NS = 40;
  localparam real MDC_REFRESH_INTERVAL_US = 11.3;
  localparam int MDC_REFRESH_CYCLES =
    int'($floor(MDC_REFRESH_INTERVAL_US * 1000.0 / MDC_CLK_PERIOD_NS));

  typedef enum logic [1:0] {
    MDC_REF_IDLE = 2'b01,
    MDC_REF_BUSY = 2'b10
  } mdc_ref_state_t;

  // register reference from the processor bus
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mdc_reg_req_t;

  // write reference toward the array
  typedef struct packed {
    logic valid;
    logic parity_err;
    logic [MDC_DATA_W-1:0] data;
  } mdc_wr_req_t;

  // raw word read back from the array
  typedef struct packed {
    logic valid;
    logic [MDC_DATA_W-1:0] data;
    logic [MDC_CHECK_W-1:0] check;
  } mdc_rd_resp_t;

  // error capture toward memory_error_status
  typedef struct packed {
    logic capture;
    logic single;
    logic uncorrectable;
    logic [MDC_CHECK_W-1:0] syndrome;
  } mdc_err_report_t;

  typedef struct packed {
    logic req;
    logic [4:0] interrupt_priority_level;
    logic [7:0] vector;
  } mdc_irq_t;
endpackage
`default_nettype wire

// ===== logic/mdc_ecc_code.sv
/*
  combinational check-bit generator and syndrome decoder.
  assumes the caller registers every result it drives out.
*/
`timescale 1ns/1ps
`default_nettype none
module mdc_ecc_code
  import mdc_pkg::*;
#(
  parameter int DATA_W = MDC_DATA_W,
  parameter int CHECK_W = MDC_CHECK_W
) (
  input wire logic [DATA_W-1:0] data_in,
  input wire logic [CHECK_W-1:0] check_in,
  output logic [CHECK_W-1:0] gen_out,
  output logic [CHECK_W-1:0] syndrome_out,
  output logic [DATA_W-1:0] corrected_out,
  output logic correctable_out,
  output logic uncorrectable_out
);
  // column code of data bit j: j-th code of weight three
  function automatic logic [CHECK_W-1:0] col_code(input int j);
    int n;
    logic [CHECK_W-1:0] r;
    n = 0;
    r = '0;
    for (int v = 1; v < (1 << CHECK_W); v++) begin
      if ($countones(v) == 3) begin
        if (n == j) begin
          r = CHECK_W'(v);
        end
        n++;
      end
    end
    return r;
  endfunction

  logic [CHECK_W-1:0] syn;
  logic data_hit;

  // generate, compare, then flip the single data bit named
  always_comb begin
    gen_out = '0;
    for (int j = 0; j < DATA_W; j++) begin
      if (data_in[j]) begin
        gen_out = gen_out ^ col_code(j);
      end
    end
    syn = gen_out ^ check_in;
    syndrome_out = syn;
    corrected_out = data_in;
    data_hit = 1'b0;
    for (int j = 0; j < DATA_W; j++) begin
      if (syn == col_code(j)) begin
        corrected_out[j] = ~data_in[j];
        data_hit = 1'b1;
      end
    end
    // check-bit errors have weight one and leave data alone
    correctable_out = data_hit | ($countones(syn) == 1);
    uncorrectable_out = (syn != '0) & ~correctable_out;
  end
endmodule
`default_nettype wire

// ===== logic/mdc_ctrl.sv
/*
  memory_diag_control register with refresh forcing, diagnostic
  check-bit substitution and capture, and corrected read reporting.
  assumes all inputs synchronous to clk_in; the array controller
  answers each refresh request with a one-cycle refresh_done_in.
*/
`timescale 1ns/1ps
`default_nettype none
module mdc_ctrl
  import mdc_pkg::*;
#(
  parameter int REFRESH_CYCLES = MDC_REFRESH_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic dc_power_good_in,
  input wire logic cpu_halted_in,
  input wire mdc_reg_req_t reg_req_in,
  output logic reg_ack_out,
  output logic [31:0] reg_rdata_out,
  input wire logic refresh_done_in,
  output logic refresh_req_out,
  input wire mdc_wr_req_t wr_req_in,
  output logic wr_valid_out,
  output logic [MDC_DATA_W-1:0] wr_data_out,
  output logic [MDC_CHECK_W-1:0] wr_check_out,
  input wire mdc_rd_resp_t rd_resp_in,
  output logic rd_valid_out,
  output logic [MDC_DATA_W-1:0] rd_data_out,
  output mdc_err_report_t err_report_out,
  output mdc_irq_t crd_irq_out
);
  localparam int CNT_W = $clog2(REFRESH_CYCLES);

  logic crd_ie, force_ref, det_dis, diag_mode, dc_prev;
  logic [MDC_CHECK_W-1:0] check_bits;
  logic next_crd_ie, next_force_ref, next_det_dis, next_diag_mode;
  logic [MDC_CHECK_W-1:0] next_check_bits;
  logic next_reg_ack;
  logic [31:0] next_reg_rdata, ctrl_image;
  logic reg_hit, reg_wr, soft_clr;

  logic [MDC_CHECK_W-1:0] wr_gen, rd_gen, rd_syn;
  logic [MDC_DATA_W-1:0] rd_fixed;
  logic rd_corr, rd_unc;

  // write side generator and read side checker
  mdc_ecc_code u_wr_code (
    .data_in(wr_req_in.data),
    .check_in('0),
    .gen_out(wr_gen),
    .syndrome_out(),
    .corrected_out(),
    .correctable_out(),
    .uncorrectable_out()
  );

  mdc_ecc_code u_rd_code (
    .data_in(rd_resp_in.data),
    .check_in(rd_resp_in.check),
    .gen_out(rd_gen),
    .syndrome_out(rd_syn),
    .corrected_out(rd_fixed),
    .correctable_out(rd_corr),
    .uncorrectable_out(rd_unc)
  );

  mdc_ref_state_t ref_state, next_ref_state;
  logic [CNT_W-1:0] ref_timer, next_ref_timer;
  logic auto_pend, next_auto_pend, ref_forced, next_ref_forced;
  logic next_refresh_req;

  // register decode and control field updates
  always_comb begin
    reg_hit = reg_req_in.valid & ((reg_req_in.addr == MDC_ADDR_MAIN) |
                                  (reg_req_in.addr == MDC_ADDR_DIAG));
    reg_wr = reg_hit & reg_req_in.write;
    soft_clr = dc_prev & ~dc_power_good_in & cpu_halted_in;
    ctrl_image = MDC_CTRL_RESET;
    ctrl_image[MDC_CRD_IE_BIT] = crd_ie;
    ctrl_image[MDC_FORCE_REF_BIT] = force_ref;
    ctrl_image[MDC_DET_DIS_BIT] = det_dis;
    ctrl_image[MDC_DIAG_MODE_BIT] = diag_mode;
    ctrl_image[MDC_CHECK_LSB +: MDC_CHECK_W] = check_bits;
    next_crd_ie = crd_ie;
    next_force_ref = force_ref;
    next_det_dis = det_dis;
    next_diag_mode = diag_mode;
    next_check_bits = check_bits;
    if (rd_resp_in.valid && !diag_mode) begin
      next_check_bits = rd_resp_in.check;
    end
    if (ref_state == MDC_REF_BUSY && ref_forced && refresh_done_in) begin
      next_force_ref = 1'b0;
    end
    // a software write wins over completion and capture
    if (reg_wr) begin
      next_crd_ie = reg_req_in.wdata[MDC_CRD_IE_BIT];
      next_force_ref = reg_req_in.wdata[MDC_FORCE_REF_BIT];
      next_det_dis = reg_req_in.wdata[MDC_DET_DIS_BIT];
      next_diag_mode = reg_req_in.wdata[MDC_DIAG_MODE_BIT];
      next_check_bits = reg_req_in.wdata[MDC_CHECK_LSB +: MDC_CHECK_W];
    end
    if (soft_clr) begin
      next_crd_ie = 1'b0;
      next_force_ref = 1'b0;
      next_det_dis = 1'b0;
      next_diag_mode = 1'b0;
      next_check_bits = '0;
    end
    next_reg_ack = reg_hit;
    next_reg_rdata = (reg_hit && !reg_req_in.write) ? ctrl_image : '0;
  end

  // control register state
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      crd_ie <= 1'b0;
      force_ref <= 1'b0;
      det_dis <= 1'b0;
      diag_mode <= 1'b0;
      check_bits <= '0;
      dc_prev <= 1'b1;
      reg_ack_out <= 1'b0;
      reg_rdata_out <= '0;
    end else begin
      crd_ie <= next_crd_ie;
      force_ref <= next_force_ref;
      det_dis <= next_det_dis;
      diag_mode <= next_diag_mode;
      check_bits <= next_check_bits;
      dc_prev <= dc_power_good_in;
      reg_ack_out <= next_reg_ack;
      reg_rdata_out <= next_reg_rdata;
    end
  end

  // refresh interval timer and request sequencer
  always_comb begin
    next_ref_state = ref_state;
    next_ref_forced = ref_forced;
    next_auto_pend = auto_pend;
    next_refresh_req = refresh_req_out;
    next_ref_timer = ref_timer + CNT_W'(1);
    if (ref_timer == CNT_W'(REFRESH_CYCLES - 1)) begin
      next_ref_timer = '0;
    end
    unique case (ref_state)
      MDC_REF_IDLE: begin
        if (force_ref) begin
          next_ref_state = MDC_REF_BUSY;
          next_ref_forced = 1'b1;
          next_refresh_req = 1'b1;
        end else if (auto_pend) begin
          next_ref_state = MDC_REF_BUSY;
          next_ref_forced = 1'b0;
          next_refresh_req = 1'b1;
          next_auto_pend = 1'b0;
        end
      end
      MDC_REF_BUSY: begin
        if (refresh_done_in) begin
          next_ref_state = MDC_REF_IDLE;
          next_refresh_req = 1'b0;
          next_ref_forced = 1'b0;
        end
      end
    endcase
    // a due interval is kept pending behind a busy cycle, but is dropped while force_ref is set
    if (ref_timer == CNT_W'(REFRESH_CYCLES - 1) && !force_ref) begin
      next_auto_pend = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ref_state <= MDC_REF_IDLE;
      ref_timer <= '0;
      auto_pend <= 1'b0;
      ref_forced <= 1'b0;
      refresh_req_out <= 1'b0;
    end else begin
      ref_state <= next_ref_state;
      ref_timer <= next_ref_timer;
      auto_pend <= next_auto_pend;
      ref_forced <= next_ref_forced;
      refresh_req_out <= next_refresh_req;
    end
  end

  logic next_wr_valid, next_rd_valid;
  logic [MDC_DATA_W-1:0] next_wr_data, next_rd_data;
  logic [MDC_CHECK_W-1:0] next_wr_check;
  mdc_err_report_t next_err;
  mdc_irq_t next_irq;

  // array write check selection and read correction
  always_comb begin
    next_wr_valid = wr_req_in.valid;
    next_wr_data = wr_req_in.data;
    if (diag_mode) begin
      next_wr_check = check_bits;
    end else if (wr_req_in.parity_err) begin
      next_wr_check = wr_gen ^ MDC_PARITY_FLIP;
    end else begin
      next_wr_check = wr_gen;
    end
    next_rd_valid = rd_resp_in.valid;
    next_rd_data = det_dis ? rd_resp_in.data : rd_fixed;
    next_err = '0;
    next_irq.req = 1'b0;
    next_irq.interrupt_priority_level = MDC_CRD_IPL;
    next_irq.vector = MDC_CRD_VECTOR;
    if (rd_resp_in.valid && !det_dis) begin
      next_err.capture = rd_corr | rd_unc;
      next_err.single = rd_corr;
      next_err.uncorrectable = rd_unc;
      next_err.syndrome = rd_syn;
      next_irq.req = rd_corr & crd_ie;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_valid_out <= 1'b0;
      wr_data_out <= '0;
      wr_check_out <= '0;
      rd_valid_out <= 1'b0;
      rd_data_out <= '0;
      err_report_out <= '0;
      crd_irq_out <= '0;
    end else begin
      wr_valid_out <= next_wr_valid;
      wr_data_out <= next_wr_data;
      wr_check_out <= next_wr_check;
      rd_valid_out <= next_rd_valid;
      rd_data_out <= next_rd_data;
      err_report_out <= next_err;
      crd_irq_out <= next_irq;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_force_written;
    reg_wr && reg_req_in.wdata[MDC_FORCE_REF_BIT] && !soft_clr &&
      ref_state == MDC_REF_IDLE && !auto_pend && !force_ref;
  endsequence
  sequence s_forced_issue;
    force_ref ##1 (refresh_req_out && ref_forced);
  endsequence

  a_reserved_zero: assert property (
    reg_ack_out |-> reg_rdata_out[31:13] == '0 && reg_rdata_out[9:8] == '0)
    else $error("reserved field read nonzero");
  a_dual_decode: assert property (
    reg_req_in.valid && (reg_req_in.addr == MDC_ADDR_MAIN || reg_req_in.addr == MDC_ADDR_DIAG)
      |=> reg_ack_out)
    else $error("register address not acknowledged");
  a_crd_quiet: assert property (
    rd_resp_in.valid && !crd_ie |=> !crd_irq_out.req)
    else $error("interrupt raised while enable clear");
  a_crd_raise: assert property (
    rd_resp_in.valid && !det_dis && crd_ie && rd_corr
      |=> crd_irq_out.req && crd_irq_out.interrupt_priority_level == 5'h1A && crd_irq_out.vector == 8'h54)
    else $error("corrected read interrupt missing");
  a_capture_any: assert property (
    rd_resp_in.valid && !det_dis && rd_unc |=> err_report_out.capture && err_report_out.uncorrectable)
    else $error("uncorrectable error not captured");
  a_auto_refresh: assert property (
    ref_timer == CNT_W'(REFRESH_CYCLES - 1) && ref_state == MDC_REF_IDLE && !auto_pend &&
      !force_ref && !reg_req_in.valid |-> ##2 refresh_req_out && !ref_forced)
    else $error("periodic refresh not issued");
  a_force_once: assert property (
    s_force_written |=> s_forced_issue)
    else $error("forced refresh not issued after write");
  a_force_clear: assert property (
    refresh_req_out && ref_forced && refresh_done_in && !reg_wr |=> !force_ref && !refresh_req_out)
    else $error("force bit not cleared on completion");
  a_detect_off: assert property (
    rd_resp_in.valid && det_dis
      |=> !err_report_out.capture && !crd_irq_out.req && rd_data_out == $past(rd_resp_in.data))
    else $error("error reported while detection disabled");
  a_diag_check: assert property (
    wr_req_in.valid && diag_mode |=> wr_check_out == $past(check_bits))
    else $error("diagnostic check bits not substituted");
  a_normal_check: assert property (
    wr_req_in.valid && !diag_mode && !wr_req_in.parity_err |=> wr_check_out == $past(wr_gen))
    else $error("generated check bits not stored");
  a_parity_flip: assert property (
    wr_req_in.valid && !diag_mode && wr_req_in.parity_err |=> wr_check_out == ($past(wr_gen) ^ 7'h07))
    else $error("parity error check bits wrong");
  a_check_capture: assert property (
    rd_resp_in.valid && !diag_mode && !reg_wr && !soft_clr |=> check_bits == $past(rd_resp_in.check))
    else $error("stored check bits not captured");
  a_soft_clear: assert property (
    soft_clr |=> !crd_ie && !force_ref && !det_dis && !diag_mode && check_bits == '0)
    else $error("register not cleared on power-good loss");
  a_clean_word: assert property (
    rd_resp_in.valid && !det_dis && rd_resp_in.check == rd_gen
      |=> !err_report_out.capture && rd_data_out == $past(rd_resp_in.data))
    else $error("clean word flagged or altered");
endmodule
`default_nettype wire

// ===== verification/mdc_array_model.sv
/*
  array-side model: answers refresh requests, keeps the last written word.
  assumes the bench pulses rd_go_in for one cycle to replay that word with flips.
*/
`timescale 1ns/1ps
`default_nettype none
module mdc_array_model
  import mdc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic slow_in,
  input wire logic refresh_req_in,
  output logic refresh_done_out,
  input wire logic wr_valid_in,
  input wire logic [MDC_DATA_W-1:0] wr_data_in,
  input wire logic [MDC_CHECK_W-1:0] wr_check_in,
  input wire logic rd_go_in,
  input wire logic [38:0] rd_flip_in,
  output mdc_rd_resp_t rd_resp_out
);
  logic [38:0] word;
  logic [3:0] wait_cnt;
  logic done_seen;

  // refresh answer after 2 or 6 cycles, one done pulse per request
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_cnt <= 4'h0;
      done_seen <= 1'b0;
      refresh_done_out <= 1'b0;
    end else begin
      refresh_done_out <= 1'b0;
      if (!refresh_req_in) begin
        wait_cnt <= 4'h0;
        done_seen <= 1'b0;
      end else if (!done_seen) begin
        wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt == (slow_in ? 4'h5 : 4'h1)) begin
          refresh_done_out <= 1'b1;
          done_seen <= 1'b1;
        end
      end
    end
  end

  // store writes; idle read lines toggle so stale data never looks valid
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      word <= '0;
      rd_resp_out <= '0;
    end else begin
      if (wr_valid_in) begin
        word <= {wr_check_in, wr_data_in};
      end
      if (rd_go_in) begin
        rd_resp_out <= {1'b1, word[31:0] ^ rd_flip_in[31:0], word[38:32] ^ rd_flip_in[38:32]};
      end else begin
        rd_resp_out <= {1'b0, ~rd_resp_out.data, ~rd_resp_out.check};
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
/*
  self-checking bench for mdc_ctrl with the array model on its far side.
  assumes the handover timing: one-cycle requests, answers one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mdc_pkg::*;
  localparam int RC = 40;
  localparam logic [31:0] D = 32'ha5c3_1e69;
  logic clk_in, rst_n_in, pg, halted, slow, rd_go, ref_done, ref_req, ref_prev;
  logic reg_ack_out, wr_valid_out, rd_valid_out;
  logic [31:0] reg_rdata_out, wr_data_out, rd_data_out;
  logic [6:0] wr_check_out;
  logic [38:0] rd_flip;
  mdc_reg_req_t reg_req;
  mdc_wr_req_t wr_req;
  mdc_rd_resp_t rd_resp;
  mdc_err_report_t err_rep;
  mdc_irq_t irq;
  int bad_count = 0, checks_done = 0, rises = 0, cycles = 0, base;
  time last_rise, t0;

  mdc_ctrl #(.REFRESH_CYCLES(RC)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .dc_power_good_in(pg),
    .cpu_halted_in(halted), .reg_req_in(reg_req), .reg_ack_out(reg_ack_out), .reg_rdata_out(reg_rdata_out),
    .refresh_done_in(ref_done), .refresh_req_out(ref_req), .wr_req_in(wr_req), .wr_valid_out(wr_valid_out),
    .wr_data_out(wr_data_out), .wr_check_out(wr_check_out), .rd_resp_in(rd_resp), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out), .err_report_out(err_rep), .crd_irq_out(irq));

  mdc_array_model model (.clk_in(clk_in), .rst_n_in(rst_n_in), .slow_in(slow), .refresh_req_in(ref_req),
    .refresh_done_out(ref_done), .wr_valid_in(wr_valid_out), .wr_data_in(wr_data_out),
    .wr_check_in(wr_check_out), .rd_go_in(rd_go), .rd_flip_in(rd_flip), .rd_resp_out(rd_resp));

  // expected check bits: weight-three columns in ascending order
  function automatic logic [6:0] gen(input logic [31:0] d);
    logic [6:0] g;
    int k;
    g = 7'h00;
    k = 0;
    for (int v = 0; v < 128; v++) begin
      if ($countones(v[6:0]) == 3 && k < 32) begin
        if (d[k]) g ^= v[6:0];
        k++;
      end
    end
    return g;
  endfunction

  task automatic end_sim();
    if (bad_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // register reference: request for one cycle, ack and data in the next, then one idle cycle
  task automatic reg_acc(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic hit,
                         input logic [31:0] exp);
    reg_req = '{1'b1, wr, a, d};
    @(posedge clk_in);
    #1;
    reg_req = '0;
    chk({7'h0, reg_ack_out, reg_rdata_out}, {7'h0, hit, exp});
    @(posedge clk_in);
    #1;
  endtask

  // unmasked write reference only; idle cycle lets the array store the word
  task automatic mem_wr(input logic [31:0] d, input logic pe, input logic [6:0] exp_chk);
    wr_req = '{1'b1, pe, d};
    @(posedge clk_in);
    #1;
    wr_req = '0;
    chk({wr_valid_out, wr_check_out, wr_data_out}, {1'b1, exp_chk, d});
    @(posedge clk_in);
    #1;
  endtask

  // flags: capture, single, uncorrectable, interrupt request
  task automatic mem_rd(input logic [38:0] flip, input logic cmp_d, input logic [31:0] exp_d,
                        input logic [3:0] flags, input logic [6:0] syn);
    rd_flip = flip;
    rd_go = 1'b1;
    @(posedge clk_in);
    #1;
    rd_go = 1'b0;
    @(posedge clk_in);
    #1;
    chk({3'h0, rd_valid_out, err_rep.capture, err_rep.single, err_rep.uncorrectable, irq.req,
         cmp_d ? rd_data_out : 32'h0}, {3'h0, 1'b1, flags, cmp_d ? exp_d : 32'h0});
    if (flags[3]) chk({33'h0, err_rep.syndrome}, {33'h0, syn});
  endtask

  task automatic wait_rises(input int n);
    for (int i = 0; i < 300 && rises < n; i++) begin
      @(posedge clk_in);
    end
    #1;
  endtask

  // clock
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // refresh rise monitor and run ceiling
  always @(posedge clk_in) begin
    ref_prev <= ref_req;
    cycles <= cycles + 1;
    if (ref_req && !ref_prev) begin
      rises <= rises + 1;
      last_rise <= $time;
    end
    if (cycles == 6000) begin
      bad_count++;
      end_sim();
    end
  end

  // main sequence
  initial begin
    rst_n_in = 1'b0;
    pg = 1'b1;
    halted = 1'b0;
    slow = 1'b0;
    rd_go = 1'b0;
    rd_flip = '0;
    reg_req = '0;
    wr_req = '0;
    repeat (12) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    @(posedge clk_in);
    #1;
    reg_acc(1'b0, 32'h1008_0144, 32'h0, 1'b1, 32'h0);
    reg_acc(1'b0, 32'h2008_0144, 32'h0, 1'b1, 32'h0);
    reg_acc(1'b0, 32'h1008_0148, 32'h0, 1'b0, 32'h0);
    wait_rises(1);
    t0 = last_rise;
    wait_rises(2);
    chk(40'(last_rise - t0), 40'(RC * 40));
    reg_acc(1'b1, 32'h2008_0144, 32'h0000_14ff, 1'b1, 32'h0);
    reg_acc(1'b0, 32'h1008_0144, 32'h0, 1'b1, 32'h0000_14ff);
    reg_acc(1'b1, 32'h1008_0144, 32'h0, 1'b1, 32'h0);
    // forced refresh just after an automatic one, slow answers
    slow = 1'b1;
    wait_rises(3);
    base = rises;
    reg_acc(1'b1, 32'h1008_0144, 32'h0000_0800, 1'b1, 32'h0);
    repeat (25) @(posedge clk_in);
    #1;
    chk(40'(rises - base), 40'h1);
    reg_acc(1'b0, 32'h1008_0144, 32'h0, 1'b1, 32'h0);
    slow = 1'b0;
    // forced refresh from idle, fast answers
    reg_acc(1'b1, 32'h1008_0144, 32'h0000_0800, 1'b1, 32'h0);
    repeat (3) @(posedge clk_in);
    #1;
    chk(40'(rises - base), 40'h2);
    mem_wr(D, 1'b0, gen(D));
    mem_wr(D, 1'b1, gen(D) ^ 7'h07);
    mem_wr(D, 1'b0, gen(D));
    mem_rd(39'h20, 1'b1, D, 4'b1100, gen(32'h20));
    reg_acc(1'b0, 32'h1008_0144, 32'h0, 1'b1, {25'h0, gen(D)});
    mem_rd(39'h1_0000_0000, 1'b1, D, 4'b1100, 7'h01);
    reg_acc(1'b1, 32'h1008_0144, 32'h0000_1000, 1'b1, 32'h0);
    mem_rd(39'h20, 1'b1, D, 4'b1101, gen(32'h20));
    chk({27'h0, irq.interrupt_priority_level, irq.vector}, {27'h0, 5'h1a, 8'h54});
    mem_rd(39'h220, 1'b0, D, 4'b1010, gen(32'h220));
    reg_acc(1'b1, 32'h1008_0144, 32'h0000_1400, 1'b1, 32'h0);
    mem_rd(39'h20, 1'b1, D ^ 32'h20, 4'b0000, 7'h0);
    reg_acc(1'b1, 32'h1008_0144, 32'h0000_00d5, 1'b1, 32'h0);
    mem_wr(D, 1'b1, 7'h55);
    // power-good loss clears only while halted
    reg_acc(1'b1, 32'h1008_0144, 32'h0000_14ff, 1'b1, 32'h0);
    pg = 1'b0;
    @(posedge clk_in);
    #1;
    pg = 1'b1;
    reg_acc(1'b0, 32'h1008_0144, 32'h0, 1'b1, 32'h0000_14ff);
    halted = 1'b1;
    pg = 1'b0;
    @(posedge clk_in);
    #1;
    @(posedge clk_in);
    #1;
    reg_acc(1'b0, 32'h1008_0144, 32'h0, 1'b1, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
